// [gpp_ahb_slave.sv]
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_ahb_slave (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [7:0] rd_value_i,
  output gpp_pkg::gpp_bus_req_t req_o
);
  import gpp_pkg::*;

  gpp_slv_state_t s;
  gpp_slv_state_t next_s;
  logic accept;
  logic addr_hit;

  // Only the three port registers decode; all else reads zero, writes drop.
  assign addr_hit = (haddr_i == gpp_reg_addr(`GPP_IDX_PORT2_DATA)) ||
                    (haddr_i == gpp_reg_addr(`GPP_IDX_PORT4_DATA)) ||
                    (haddr_i == gpp_reg_addr(`GPP_IDX_PORT2_DIR));
  assign accept = hsel_i && htrans_i[`GPP_HTRANS_ACTIVE_BIT] && hready_i;

  // Reads take one wait state so the value is captured in a flop after
  // any write in the preceding data phase has landed.
  always_comb begin
    next_s = s;
    next_s.ph_write = 1'b0;
    if (s.ph_read && s.ph_wait) begin
      next_s.ph_wait = 1'b0;
      next_s.rdata = {24'h000000, s.hit ? rd_value_i : `GPP_UNMAPPED_READ};
    end else begin
      next_s.ph_read = 1'b0;
    end
    if (accept) begin
      next_s.ph_write = hwrite_i;
      next_s.ph_read = !hwrite_i;
      next_s.ph_wait = !hwrite_i;
      next_s.hit = addr_hit;
      next_s.idx = haddr_i[`GPP_IDX_MSB:`GPP_IDX_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Write strobe acts at the edge closing the data phase.
  assign req_o.wr = s.ph_write && s.hit;
  assign req_o.idx = s.idx;
  assign req_o.wdata = hwdata_i[7:0];
  assign hreadyout_o = !(s.ph_read && s.ph_wait);
  assign hresp_o = `GPP_HRESP_OKAY;
  assign hrdata_o = s.rdata;
endmodule

// [gpp_asserts.sv]
`timescale 1ns/1ps
module gpp_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic [31:0] hrdata_o,
  input wire gpp_pkg::gpp_mode_t op_mode_i,
  input wire logic [7:0] p2_oe_o,
  input wire logic [5:0] p4_out_o,
  input wire logic [5:0] p4_oe_o,
  input wire logic first_port_top_pin_oe_o
);
  import gpp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // A transfer to one register accepted at this edge.
  sequence s_take(a, w);
    hsel_i && htrans_i[1] && hready_i && hwrite_i == w && haddr_i == a;
  endsequence
  // A write, its data phase, then the first cycle the pins may react.
  sequence s_wr(a);
    s_take(a, 1'b1) ##2 op_mode_i == gpp_mode_active;
  endsequence
  property p_wr_dir;
    s_wr(32'h3FF88) |-> p2_oe_o == $past(hwdata_i[7:0]);
  endproperty
  a_wr_dir: assert property (p_wr_dir)
    else $error("direction write missed the pins");
  property p_wr_p4;
    s_wr(32'h3FF50) |-> p4_oe_o == $past(hwdata_i[5:0]);
  endproperty
  a_wr_p4: assert property (p_wr_p4)
    else $error("port 4 write missed the pins");
  property p_rd_dir;
    s_take(32'h3FF88, 1'b0) |-> ##2 hreadyout_o && hrdata_o == 32'hFF;
  endproperty
  a_rd_dir: assert property (p_rd_dir)
    else $error("direction read not all ones");
  property p_rd_wait;
    s_take(haddr_i, 1'b0) |-> ##1 !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_p4_high;
    p4_out_o == 6'h3F;
  endproperty
  a_p4_high: assert property (p_p4_high)
    else $error("port 4 drives low");
  property p_rst;
    disable iff (1'b0)
    !resetn_i |-> !p2_oe_o && !p4_oe_o && !first_port_top_pin_oe_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pin driven in reset");
  property p_stop;
    op_mode_i inside {gpp_mode_standby, gpp_mode_watch, gpp_mode_subactive}
      |-> !p2_oe_o && !p4_oe_o && !first_port_top_pin_oe_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("pin driven while stopped");
  property p_sleep;
    op_mode_i == gpp_mode_sleep && $past(op_mode_i) == gpp_mode_sleep
      && $past(resetn_i) |-> $stable({p2_oe_o, p4_oe_o});
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("pins moved in sleep");
endmodule
bind gpp_port_ctrl gpp_chk u_chk (.*);

// [gpp_board.sv]
`timescale 1ns/1ps
module gpp_board (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  output logic [7:0] lvl_o
);
  // The chip wins where it drives; elsewhere the board sets the level.
  assign lvl_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule

// [gpp_defs.svh]
// Overview of operation
// - Port 2 direction bit 1 makes that pin an output, 0 an input.
// - Port 2 direction register is write-only and always reads as all ones.
// - Reset clears port 2 direction to zero, all port 2 pins inputs.
// - Port 2 output pins read back the stored data bit, not the pin.
// - Port 2 input pins read back the level sampled on the pin.
// - Reset clears all eight port 2 data bits to zero.
// - Port 2: float/pull-up in reset, hold in sleep, float when stopped.
// - First port top pin floats in reset, holds in sleep, floats when stopped.
// - Port 4 six pins drive only high, never actively low.
// - Port 4 data bits 7 and 6 read as one and ignore writes.
// - Reset sets port 4 data to upper two ones, six zeros.
// - Port 4 data 0 floats the pin, 1 drives it high.
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// Register indices; the byte address is four times the index.
`define GPP_IDX_PORT2_DATA 16'hFFD2
`define GPP_IDX_PORT4_DATA 16'hFFD4
`define GPP_IDX_PORT2_DIR 16'hFFE2
`define GPP_IDX_LSB 2
`define GPP_IDX_MSB 17

// Reset values and fixed read patterns.
`define GPP_PORT2_DATA_RST 8'h00
`define GPP_PORT2_DIR_RST 8'h00
`define GPP_PORT4_DATA_RST 8'hC0
`define GPP_PORT4_RSVD_BITS 2'h3
`define GPP_DIR_READ_VALUE 8'hFF
`define GPP_UNMAPPED_READ 8'h00

// Bus encodings.
`define GPP_HTRANS_ACTIVE_BIT 1
`define GPP_HRESP_OKAY 1'h0

`endif

// [gpp_pkg.sv]
package gpp_pkg;

  // Operating mode of the chip as seen by the pin drivers.
  typedef enum logic [2:0] {
    gpp_mode_active,
    gpp_mode_sleep,
    gpp_mode_standby,
    gpp_mode_watch,
    gpp_mode_subactive
  } gpp_mode_t;

  // Register access handed from the bus slave to the port logic.
  typedef struct packed {
    logic wr;
    logic [15:0] idx;
    logic [7:0] wdata;
  } gpp_bus_req_t;

  // Bus slave state.
  typedef struct packed {
    logic ph_write;
    logic ph_read;
    logic ph_wait;
    logic hit;
    logic [15:0] idx;
    logic [31:0] rdata;
  } gpp_slv_state_t;

  // Port register and sleep hold state.
  typedef struct packed {
    logic [7:0] p2_dir;
    logic [7:0] p2_data;
    logic [5:0] p4_data;
    logic [7:0] hold_p2_out;
    logic [7:0] hold_p2_oe;
    logic [5:0] hold_p4_oe;
    logic hold_p1_out;
    logic hold_p1_oe;
  } gpp_regs_t;

  // Byte address of a register given its index.
  function automatic logic [31:0] gpp_reg_addr(input logic [15:0] idx);
    gpp_reg_addr = {14'h0000, idx, 2'h0};
  endfunction

endpackage

// [gpp_port_ctrl.sv]
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_port_ctrl #(
  parameter int P2_W = 8,
  parameter int P4_W = 6,
  parameter int P1_LOW_W = 7
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input gpp_pkg::gpp_mode_t op_mode_i,
  input wire logic [P2_W-1:0] p2_in_i,
  output logic [P2_W-1:0] p2_out_o,
  output logic [P2_W-1:0] p2_oe_o,
  output logic [P2_W-1:0] p2_pullup_o,
  output logic [P4_W-1:0] p4_out_o,
  output logic [P4_W-1:0] p4_oe_o,
  input wire logic p1_top_out_i,
  input wire logic p1_top_oe_i,
  output logic first_port_top_pin_out_o,
  output logic first_port_top_pin_oe_o,
  output logic [P1_LOW_W-1:0] p1_low_pullup_o
);
  import gpp_pkg::*;

  gpp_regs_t r;
  gpp_regs_t next_r;
  gpp_bus_req_t req;
  logic [7:0] rd_value;
  logic [7:0] p2_read;
  logic in_reset;
  logic sleeping;
  logic running;

  // Transfer size is not checked: only whole-word accesses are issued and
  // the registers live in the low byte of each word.
  gpp_ahb_slave u_slave (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .rd_value_i(rd_value),
    .req_o(req)
  );

  // Mixed readback: output pins show the latch, input pins show the wire.
  assign p2_read = (r.p2_dir & r.p2_data) |
                   (~r.p2_dir & p2_in_i);

  // Read value for the index captured by the slave.
  always_comb begin
    if (req.idx == `GPP_IDX_PORT2_DATA) begin
      rd_value = p2_read;
    end else if (req.idx == `GPP_IDX_PORT4_DATA) begin
      rd_value = {`GPP_PORT4_RSVD_BITS, r.p4_data};
    end else if (req.idx == `GPP_IDX_PORT2_DIR) begin
      rd_value = `GPP_DIR_READ_VALUE;
    end else begin
      rd_value = `GPP_UNMAPPED_READ;
    end
  end

  // Register writes and the sleep snapshot of the pin drivers.
  always_comb begin
    next_r = r;
    if (req.wr) begin
      if (req.idx == `GPP_IDX_PORT2_DATA) begin
        next_r.p2_data = req.wdata;
      end else if (req.idx == `GPP_IDX_PORT4_DATA) begin
        next_r.p4_data = req.wdata[P4_W-1:0];
      end else if (req.idx == `GPP_IDX_PORT2_DIR) begin
        next_r.p2_dir = req.wdata;
      end
    end
    // The snapshot follows the live drive only while running, so entering
    // sleep freezes whatever the pins showed in the last active cycle.
    if (op_mode_i == gpp_mode_active) begin
      next_r.hold_p2_out = r.p2_data;
      next_r.hold_p2_oe = r.p2_dir;
      next_r.hold_p4_oe = r.p4_data;
      next_r.hold_p1_out = p1_top_out_i;
      next_r.hold_p1_oe = p1_top_oe_i;
    end
  end

  // Reset loads the documented initial values.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.p2_dir <= `GPP_PORT2_DIR_RST;
      r.p2_data <= `GPP_PORT2_DATA_RST;
      // Only the six data bits are stored; the reserved ones are read-only.
      r.p4_data <= P4_W'(`GPP_PORT4_DATA_RST);
    end else begin
      r <= next_r;
    end
  end

  assign in_reset = !resetn_i;
  assign sleeping = (op_mode_i == gpp_mode_sleep);
  assign running = (op_mode_i == gpp_mode_active);

  // Port 2 drivers: float while reset is held or the clock is stopped.
  always_comb begin
    if (in_reset) begin
      p2_oe_o = '0;
      p2_out_o = '0;
    end else if (running) begin
      p2_oe_o = r.p2_dir;
      p2_out_o = r.p2_data;
    end else if (sleeping) begin
      p2_oe_o = r.hold_p2_oe;
      p2_out_o = r.hold_p2_out;
    end else begin
      p2_oe_o = '0;
      p2_out_o = r.hold_p2_out;
    end
  end

  // Pull-ups keep port 2 and the lower first-port pins from floating in reset.
  assign p2_pullup_o = {P2_W{in_reset}};
  assign p1_low_pullup_o = {P1_LOW_W{in_reset}};

  // Port 4 can only pull high, so the data level is fixed at one and the
  // enable alone decides whether the pin is driven.
  assign p4_out_o = {P4_W{1'b1}};
  always_comb begin
    if (in_reset) begin
      p4_oe_o = '0;
    end else if (running) begin
      p4_oe_o = r.p4_data;
    end else if (sleeping) begin
      p4_oe_o = r.hold_p4_oe;
    end else begin
      p4_oe_o = '0;
    end
  end

  // First port top pin gating by mode; its function comes from outside.
  always_comb begin
    if (in_reset) begin
      first_port_top_pin_oe_o = 1'b0;
      first_port_top_pin_out_o = 1'b0;
    end else if (running) begin
      first_port_top_pin_oe_o = p1_top_oe_i;
      first_port_top_pin_out_o = p1_top_out_i;
    end else if (sleeping) begin
      first_port_top_pin_oe_o = r.hold_p1_oe;
      first_port_top_pin_out_o = r.hold_p1_out;
    end else begin
      first_port_top_pin_oe_o = 1'b0;
      first_port_top_pin_out_o = r.hold_p1_out;
    end
  end
endmodule

// [test_gpio_port2_port4_pin_control.sv]
`timescale 1ns/1ps
module test_gpio_port2_port4_pin_control;
  import gpp_pkg::*;
  localparam logic [31:0] A2 = 32'h3FF48, A4 = 32'h3FF50, AD = 32'h3FF88;
  logic clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic hready_i, hreadyout_o, hresp_o, first_port_top_pin_out_o;
  logic p1_top_out_i = 1'b0, p1_top_oe_i = 1'b0, first_port_top_pin_oe_o;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [7:0] p2_in_i, p2_out_o, p2_oe_o, p2_pullup_o, ext = 8'h00;
  logic [5:0] p4_out_o, p4_oe_o;
  logic [6:0] p1_low_pullup_o;
  gpp_mode_t op_mode_i = gpp_mode_active;
  int err_total = 0, n_compared = 0, seed = 32'hD163DC2A;
  // The only slave's ready is the bus ready.
  assign hready_i = hreadyout_o;
  // All pin enables in one word, so mode checks stay on one line.
  logic [14:0] oe_all;
  assign oe_all = {first_port_top_pin_oe_o, p4_oe_o, p2_oe_o};
  always #20 clk_i = ~clk_i;
  gpp_port_ctrl u_dut (.*);
  gpp_board u_brd (.drv_i(ext), .out_i(p2_out_o), .oe_i(p2_oe_o),
    .lvl_o(p2_in_i));
  // Output pins read the register, input pins read the wire.
  function automatic logic [31:0] pin_read(logic [7:0] d, v, p);
    return {24'h0, (d & v) | (~d & p)};
  endfunction
  task automatic stop_test;
    $display("mismatches %0d of %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait so a stuck slave ends the run instead of hanging it.
  task automatic edge_rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (hreadyout_o === 1'b1) return;
    end
    err_total++;
    stop_test;
  endtask
  // One single word transfer; a read is compared with d at its last edge.
  task automatic xf(logic w, logic [31:0] a, d, string nm = "wr");
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= a;
    edge_rdy;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= w ? d : 32'h0;
    edge_rdy;
    if (!w) chk(nm, hrdata_o, d);
    chk("hresp", hresp_o, 32'h0);
  endtask
  task automatic do_rst;
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk("pullups", {p1_low_pullup_o, p2_pullup_o}, 32'h7FFF);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    ext <= 8'h5A;
    xf(1'b0, A2, 32'h5A, "p2_pins");
    xf(1'b0, A4, 32'hC0, "p4_reset");
    xf(1'b1, AD, 32'hFF);
    xf(1'b0, A2, 32'h00, "p2_reset");
  endtask
  initial begin
    logic [7:0] dir, dat;
    logic [5:0] d4;
    do_rst;
    for (int i = 0; i < 12; i++) begin
      dir = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
      dat = 8'($random(seed));
      d4 = 6'($random(seed));
      ext <= 8'($random(seed));
      p1_top_out_i <= i[0];
      p1_top_oe_i <= i[1];
      xf(1'b1, AD, {24'h0, dir});
      xf(1'b1, A2, {24'h0, dat});
      xf(1'b1, A4, {26'($random(seed)), d4});
      #1;
      chk("p2_oe", p2_oe_o, dir);
      chk("p2_out", p2_out_o & dir, dat & dir);
      chk("p4", {p4_out_o, p4_oe_o}, {6'h3F, d4});
      chk("p1_oe", first_port_top_pin_oe_o, i[1]);
      chk("p1_out", first_port_top_pin_out_o, i[0]);
      chk("pullups_off", {p1_low_pullup_o, p2_pullup_o}, 32'h0);
      @(posedge clk_i);
      xf(1'b0, A2, pin_read(dir, dat, ext), "p2_rd");
      xf(1'b0, A4, {24'h0, 2'h3, d4}, "p4_rd");
      xf(1'b0, AD, 32'hFF, "dir_rd");
    end
    xf(1'b1, 32'h3FF4C, 32'hFF);
    xf(1'b0, 32'h3FF4C, 32'h0, "unmapped");
    xf(1'b0, A4, {24'h0, 2'h3, d4}, "p4_kept");
    // Sleep keeps the last active drive even as registers change.
    p1_top_oe_i <= 1'b1;
    xf(1'b1, A4, 32'h15);
    @(posedge clk_i);
    op_mode_i <= gpp_mode_sleep;
    p1_top_oe_i <= 1'b0;
    xf(1'b1, A4, 32'h2A);
    xf(1'b1, AD, 32'h0);
    #1;
    chk("sleep", oe_all, {1'b1, 6'h15, dir});
    for (int m = 2; m < 5; m++) begin
      @(posedge clk_i);
      op_mode_i <= gpp_mode_t'(m);
      #1;
      chk("stop", oe_all, 32'h0);
      // Pins float here, so an output bit whose wire disagrees shows that
      // the readback comes from the register and not from the pin.
      if (m == 2) begin
        @(posedge clk_i);
        ext <= ~dat;
        xf(1'b1, AD, 32'hFF);
        xf(1'b0, A2, {24'h0, dat}, "p2_latch");
        xf(1'b1, AD, 32'h0);
      end
    end
    @(posedge clk_i);
    op_mode_i <= gpp_mode_active;
    #1;
    chk("wake", {p4_oe_o, p2_oe_o}, {6'h2A, 8'h00});
    @(posedge clk_i);
    do_rst;
    stop_test;
  end
  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule
